// file: hw/gdfec_pkg.sv
package gdfec_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] GDFEC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] GDFEC_ADDR_STATUS = 4'h1;
  localparam logic [3:0] GDFEC_ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] GDFEC_ADDR_IRQ_MASK = 4'h3;
  // ctrl fields
  localparam int GDFEC_CTRL_EN_POS = 0;
  localparam int GDFEC_CTRL_CLR_POS = 1;
  localparam int GDFEC_CTRL_MODE_POS = 2;
  // status and event fields
  localparam int GDFEC_ST_FAULT_POS = 0;
  localparam int GDFEC_ST_UV_POS = 1;
  localparam int GDFEC_ST_POR_POS = 2;
  localparam int GDFEC_ST_ACTIVE_POS = 3;
  localparam int GDFEC_ST_DRV_POS = 4;
  localparam int GDFEC_ST_CP_POS = 5;
  localparam int GDFEC_EV_W = 3;
  // reset values
  localparam logic [7:0] GDFEC_CTRL_RST = 8'h00;
  localparam logic [GDFEC_EV_W-1:0] GDFEC_MASK_RST = 3'h0;
  // timing
  localparam int GDFEC_CLK_MHZ = 200;
  localparam int GDFEC_POR_DG_NS = 10000;
  localparam int GDFEC_UV_DG_NS = 10000;
  localparam int GDFEC_POR_DG_CYC = (GDFEC_POR_DG_NS * GDFEC_CLK_MHZ + 999) / 1000;
  localparam int GDFEC_UV_DG_CYC = (GDFEC_UV_DG_NS * GDFEC_CLK_MHZ + 999) / 1000;
  localparam int GDFEC_CNT_W = 16;

  typedef enum logic [1:0] {
    GDFEC_UV_LATCHED = 2'b01,
    GDFEC_UV_AUTO = 2'b10
  } gdfec_uv_mode_e;

  typedef enum logic [2:0] {
    GDFEC_ST_OFF = 3'b001,
    GDFEC_ST_WAIT_EN = 3'b010,
    GDFEC_ST_RUN = 3'b100
  } gdfec_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gdfec_bus_s;

  typedef struct packed {
    logic gate_enable;
    logic pulldown_on;
    logic charge_pump_on;
    logic monitors_on;
  } gdfec_drive_s;
endpackage

// file: hw/gdfec_top.sv
`timescale 1ns/1ps
// Functional notes
// - driver-disable pin forces pull-downs, overrides all
// - serial variant waits for enable bit
// - pin variant enables automatically after power-up
// - clear bit clears faults, self-resets
// - pin variant: faults recover automatically
// - logic undervoltage or sleep low: inactive
// - resume when undervoltage ends or sleep high
// - reset flag set after reset until clear; pin variant clears it when the logic supply recovers
// - supply undervoltage: pull-downs, pump off, fault
// - mode selects latched or automatic recovery
// - latched: fault and pump off until clear
// - automatic: fault released, pump restarts
// - serial automatic: undervoltage flag stays until clear; pin variant clears it when the supply recovers
// - pin variant always automatic recovery
module gdfec_top #(
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter int POR_DG_CYC = gdfec_pkg::GDFEC_POR_DG_CYC,
  parameter int UV_DG_CYC = gdfec_pkg::GDFEC_UV_DG_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins and analogue comparators
  input wire logic driver_disable_pin,
  input wire logic sleep_n_pin,
  input wire logic logic_supply_low,
  input wire logic power_supply_low,
  output logic fault_n_pin_o,
  output logic fault_n_pin_oe_n,
  // drive controls
  output gdfec_pkg::gdfec_drive_s drive_q,
  // register port
  input wire gdfec_pkg::gdfec_bus_s bus,
  output logic [7:0] rdata_q,
  output logic irq_q
);
  import gdfec_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  assign pin_raw = {power_supply_low, logic_supply_low, sleep_n_pin, driver_disable_pin};
  // one two-stage chain per pin; only the second stage is ever read
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end
  logic drv_off_s;
  logic sleep_n_s;
  logic logic_supply_low_s;
  logic power_supply_low_s;
  assign drv_off_s = sync2_q[0];
  assign sleep_n_s = sync2_q[1];
  assign logic_supply_low_s = sync2_q[2];
  assign power_supply_low_s = sync2_q[3];

  // ****************************************
  // deglitch timers
  // ****************************************
  // a dip shorter than the timer leaves no trace
  logic [GDFEC_CNT_W-1:0] por_cnt_q;
  logic [GDFEC_CNT_W-1:0] uv_cnt_q;
  logic por_det_q;
  logic uv_det_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_cnt_q <= '0;
      por_det_q <= 1'b0;
    end else if (!logic_supply_low_s) begin
      por_cnt_q <= '0;
      por_det_q <= 1'b0;
    end else if (por_cnt_q >= GDFEC_CNT_W'(POR_DG_CYC - 1)) begin
      por_det_q <= 1'b1;
    end else begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end
  logic active;
  // uv timer held off while inactive, as the monitors are down then
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_cnt_q <= '0;
      uv_det_q <= 1'b0;
    end else if (!power_supply_low_s || !active) begin
      uv_cnt_q <= '0;
      uv_det_q <= 1'b0;
    end else if (uv_cnt_q >= GDFEC_CNT_W'(UV_DG_CYC - 1)) begin
      uv_det_q <= 1'b1;
    end else begin
      uv_cnt_q <= uv_cnt_q + 1'b1;
    end
  end
  assign active = !por_det_q && sleep_n_s;

  // ****************************************
  // control register
  // ****************************************
  logic en_q;
  logic clr_q;
  logic mode_auto_q;
  logic wr_ctrl;
  // limitation: the pin variant ignores every control write
  assign wr_ctrl = bus.wr && (bus.addr == GDFEC_ADDR_CTRL);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_q <= GDFEC_CTRL_RST[GDFEC_CTRL_EN_POS];
      mode_auto_q <= GDFEC_CTRL_RST[GDFEC_CTRL_MODE_POS];
    end else if (wr_ctrl && SERIAL_VARIANT) begin
      en_q <= bus.wdata[GDFEC_CTRL_EN_POS];
      mode_auto_q <= bus.wdata[GDFEC_CTRL_MODE_POS];
    end
  end
  // clear is a single-cycle request; it drops back to zero by itself
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= wr_ctrl && SERIAL_VARIANT && bus.wdata[GDFEC_CTRL_CLR_POS];
    end
  end
  gdfec_uv_mode_e uv_mode;
  assign uv_mode = (!SERIAL_VARIANT || mode_auto_q) ? GDFEC_UV_AUTO : GDFEC_UV_LATCHED;

  // ****************************************
  // power state
  // ****************************************
  // dropping the enable bit parks the driver again
  gdfec_state_e state_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= GDFEC_ST_OFF;
    end else begin
      case (state_q)
        GDFEC_ST_OFF: begin
          if (active) begin
            state_q <= SERIAL_VARIANT ? GDFEC_ST_WAIT_EN : GDFEC_ST_RUN;
          end
        end
        GDFEC_ST_WAIT_EN: begin
          if (!active) begin
            state_q <= GDFEC_ST_OFF;
          end else if (en_q) begin
            state_q <= GDFEC_ST_RUN;
          end
        end
        GDFEC_ST_RUN: begin
          if (!active) begin
            state_q <= GDFEC_ST_OFF;
          end else if (SERIAL_VARIANT && !en_q) begin
            state_q <= GDFEC_ST_WAIT_EN;
          end
        end
        default: state_q <= GDFEC_ST_OFF;
      endcase
    end
  end

  // ****************************************
  // fault state and flags
  // ****************************************
  // set beats clear: a clear in the detect cycle does not hide the event
  logic fault_q;
  logic uv_flag_q;
  logic por_flag_q;
  logic por_det_d1_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (uv_det_q) begin
      fault_q <= 1'b1;
    end else if (uv_mode == GDFEC_UV_AUTO || clr_q) begin
      fault_q <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_flag_q <= 1'b0;
    end else if (uv_det_q) begin
      uv_flag_q <= 1'b1;
    end else if (clr_q || (!SERIAL_VARIANT && !power_supply_low_s)) begin
      uv_flag_q <= 1'b0;
    end
  end
  // the flag comes back set after a reset and after a logic-supply dropout
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_flag_q <= 1'b1;
      por_det_d1_q <= 1'b0;
    end else begin
      por_det_d1_q <= por_det_q;
      if (por_det_q) begin
        por_flag_q <= 1'b1;
      end else if (clr_q || (!SERIAL_VARIANT && por_det_d1_q)) begin
        por_flag_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // drive outputs
  // ****************************************
  logic run_ok;
  assign run_ok = (state_q == GDFEC_ST_RUN) && !fault_q && !uv_det_q;
  // pull-downs win over every drive request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_q <= '{gate_enable: 1'b0, pulldown_on: 1'b1, charge_pump_on: 1'b0, monitors_on: 1'b0};
    end else begin
      drive_q.gate_enable <= run_ok && !drv_off_s;
      drive_q.pulldown_on <= !run_ok || drv_off_s;
      drive_q.charge_pump_on <= active && !fault_q && !uv_det_q;
      drive_q.monitors_on <= active;
    end
  end
  // open drain: enable low pulls the line low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_n_pin_o <= 1'b1;
      fault_n_pin_oe_n <= 1'b1;
    end else begin
      fault_n_pin_o <= 1'b0;
      fault_n_pin_oe_n <= !(fault_q || uv_det_q);
    end
  end

  // ****************************************
  // interrupts and read port
  // ****************************************
  logic [GDFEC_EV_W-1:0] ev, ev_d1_q, irq_stat_q, irq_mask_q;
  logic rd_irq;
  assign ev = {por_flag_q, uv_flag_q, fault_q};
  assign rd_irq = bus.rd && (bus.addr == GDFEC_ADDR_IRQ_STAT);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ev_d1_q <= '0;
    end else begin
      ev_d1_q <= ev;
    end
  end
  // a rise in the read cycle survives the read, so no event is lost
  for (genvar i = 0; i < GDFEC_EV_W; i++) begin : g_irq
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        irq_stat_q[i] <= 1'b0;
      end else if (ev[i] && !ev_d1_q[i]) begin
        irq_stat_q[i] <= 1'b1;
      end else if (rd_irq) begin
        irq_stat_q[i] <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask_q <= GDFEC_MASK_RST;
    end else if (bus.wr && bus.addr == GDFEC_ADDR_IRQ_MASK) begin
      irq_mask_q <= bus.wdata[GDFEC_EV_W-1:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q & ~(rd_irq ? irq_stat_q : '0))
               || |((ev & ~ev_d1_q) & irq_mask_q);
    end
  end
  // unmapped addresses read as zero
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    if (bus.addr == GDFEC_ADDR_CTRL) begin
      rd_d[GDFEC_CTRL_EN_POS] = en_q;
      rd_d[GDFEC_CTRL_MODE_POS] = mode_auto_q;
    end else if (bus.addr == GDFEC_ADDR_STATUS) begin
      rd_d[GDFEC_ST_FAULT_POS] = fault_q;
      rd_d[GDFEC_ST_UV_POS] = uv_flag_q;
      rd_d[GDFEC_ST_POR_POS] = por_flag_q;
      rd_d[GDFEC_ST_ACTIVE_POS] = active;
      rd_d[GDFEC_ST_DRV_POS] = drive_q.gate_enable;
      rd_d[GDFEC_ST_CP_POS] = drive_q.charge_pump_on;
    end else if (bus.addr == GDFEC_ADDR_IRQ_STAT) begin
      rd_d[GDFEC_EV_W-1:0] = irq_stat_q;
    end else if (bus.addr == GDFEC_ADDR_IRQ_MASK) begin
      rd_d[GDFEC_EV_W-1:0] = irq_mask_q;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus.rd ? rd_d : 8'h00;
    end
  end
endmodule // gdfec_top

// file: dv/gdfec_mcu_model.sv
`timescale 1ns/1ps
module gdfec_mcu_model (
  // open-drain fault line
  input wire logic fault_n_pin_o,
  input wire logic fault_n_pin_oe_n,
  output logic fault_line
);
  // pull-up wins unless the device pulls low
  assign fault_line = fault_n_pin_oe_n ? 1'b1 : fault_n_pin_o;
endmodule // gdfec_mcu_model

// file: dv/gdfec_monitor.sv
`timescale 1ns/1ps
module gdfec_monitor #(
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter int UV_DG_CYC = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins
  input wire logic driver_disable_pin,
  input wire logic sleep_n_pin,
  input wire logic power_supply_low,
  input wire logic fault_n_pin_oe_n,
  // drive and bus
  input wire gdfec_pkg::gdfec_drive_s drive_q,
  input wire gdfec_pkg::gdfec_bus_s bus,
  input wire logic [7:0] rdata_q,
  input wire logic irq_q
);
  import gdfec_pkg::*;
  // ****
  // helpers
  // ****
  logic mode_q, clr_q, clr2_q;
  logic [7:0] run_q;
  wire clr_w = bus.wr && bus.addr == GDFEC_ADDR_CTRL && bus.wdata[GDFEC_CTRL_CLR_POS];
  // the pin variant always recovers on its own
  wire auto_w = mode_q || !SERIAL_VARIANT;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= 1'b0;
    end else if (bus.wr && bus.addr == GDFEC_ADDR_CTRL) begin
      mode_q <= bus.wdata[GDFEC_CTRL_MODE_POS];
    end
  end
  // clear lands two cycles late, so hold checks off meanwhile
  always_ff @(posedge sys_clk) begin
    clr_q <= clr_w;
    clr2_q <= clr_q;
    run_q <= (power_supply_low && drive_q.monitors_on) ? run_q + {7'h00, run_q != 8'hff} : 8'h00;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****
  // assertions
  // ****
  a_off_pulldown: assert property (
    driver_disable_pin [*5] |-> drive_q.pulldown_on && !drive_q.gate_enable)
    else $error("gates on while disabled");
  a_uv_fault: assert property (
    run_q == UV_DG_CYC + 6 |-> !fault_n_pin_oe_n && !drive_q.charge_pump_on)
    else $error("undervoltage not reported");
  a_fault_gates: assert property (
    !fault_n_pin_oe_n |-> drive_q.pulldown_on && !drive_q.gate_enable)
    else $error("gates on during fault");
  a_no_glitch: assert property (
    $fell(fault_n_pin_oe_n) |-> $past(run_q, 4) >= UV_DG_CYC - 2)
    else $error("fault from short glitch");
  a_sleep_off: assert property (
    !sleep_n_pin [*5] |-> !drive_q.monitors_on && !drive_q.charge_pump_on && !drive_q.gate_enable)
    else $error("active while asleep");
  a_clr_reads0: assert property (
    bus.rd && bus.addr == GDFEC_ADDR_CTRL |=> !rdata_q[GDFEC_CTRL_CLR_POS])
    else $error("clear bit stuck");
  a_auto_release: assert property (
    auto_w ##0 !power_supply_low [*6] |-> fault_n_pin_oe_n)
    else $error("auto fault not released");
  a_latch_hold: assert property (
    !auto_w && !fault_n_pin_oe_n && sleep_n_pin && !clr_w && !clr_q && !clr2_q
    |=> !fault_n_pin_oe_n && !drive_q.charge_pump_on)
    else $error("latched fault lost");
  c_fault: cover property ($fell(fault_n_pin_oe_n));
  c_irq: cover property ($rose(irq_q));
  c_gate: cover property ($rose(drive_q.gate_enable));
endmodule // gdfec_monitor
bind gdfec_top gdfec_monitor #(.SERIAL_VARIANT(SERIAL_VARIANT), .UV_DG_CYC(UV_DG_CYC)) u_mon (
  .sys_clk(sys_clk), .rst(rst),
  .driver_disable_pin(driver_disable_pin), .sleep_n_pin(sleep_n_pin),
  .power_supply_low(power_supply_low), .fault_n_pin_oe_n(fault_n_pin_oe_n),
  .drive_q(drive_q), .bus(bus), .rdata_q(rdata_q), .irq_q(irq_q));

// file: dv/gdfec_top_tb.sv
`timescale 1ns/1ps
module gdfec_top_tb;
  import gdfec_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic driver_disable_pin = 1'b0;
  logic sleep_n_pin = 1'b1;
  logic logic_supply_low = 1'b0;
  logic power_supply_low = 1'b0;
  logic fault_n_pin_o, fault_n_pin_oe_n, irq_q, fault_line;
  gdfec_drive_s drive_q;
  gdfec_bus_s bus = '0;
  logic [7:0] rdata_q, rv;
  logic pin_o, pin_oe_n, pin_irq;
  gdfec_drive_s pin_drive;
  logic [7:0] pin_rdata, pv;
  int err_count = 0;
  int checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  gdfec_top #(.SERIAL_VARIANT(1'b1), .POR_DG_CYC(8), .UV_DG_CYC(8)) u_dut (.sys_clk(sys_clk),
    .rst(rst), .driver_disable_pin(driver_disable_pin), .sleep_n_pin(sleep_n_pin),
    .logic_supply_low(logic_supply_low), .power_supply_low(power_supply_low),
    .fault_n_pin_o(fault_n_pin_o), .fault_n_pin_oe_n(fault_n_pin_oe_n), .drive_q(drive_q),
    .bus(bus), .rdata_q(rdata_q), .irq_q(irq_q));
  // pin-configured variant beside it; its control writes must be ignored
  gdfec_top #(.SERIAL_VARIANT(1'b0), .POR_DG_CYC(8), .UV_DG_CYC(8)) u_dut_pin (
    .sys_clk(sys_clk), .rst(rst), .driver_disable_pin(driver_disable_pin),
    .sleep_n_pin(sleep_n_pin), .logic_supply_low(logic_supply_low),
    .power_supply_low(power_supply_low), .fault_n_pin_o(pin_o), .fault_n_pin_oe_n(pin_oe_n),
    .drive_q(pin_drive), .bus(bus), .rdata_q(pin_rdata), .irq_q(pin_irq));
  gdfec_mcu_model u_mcu (.fault_n_pin_o(fault_n_pin_o), .fault_n_pin_oe_n(fault_n_pin_oe_n),
    .fault_line(fault_line));
  // ****
  // tasks
  // ****
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(negedge sys_clk);
    rv = rdata_q;
    pv = pin_rdata;
  endtask
  // controller clears only once the condition is gone
  task automatic t_clear(input logic m);
    wr(GDFEC_ADDR_CTRL, {5'h00, m, 2'b11});
    rd(GDFEC_ADDR_CTRL);
    chk("clr_bit", 8'(rv[GDFEC_CTRL_CLR_POS]), 8'h00);
    chk("pin_ctrl", pv, 8'h00);
    rd(GDFEC_ADDR_STATUS);
    chk("flags_clr", rv & 8'h06, 8'h00);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_power_up();
    rd(GDFEC_ADDR_STATUS);
    chk("por_flag", 8'(rv[GDFEC_ST_POR_POS]), 8'h01);
    chk("gate_idle", 8'(drive_q.gate_enable), 8'h00);
    rd(4'hf);
    chk("unmapped", rv, 8'h00);
    wr(GDFEC_ADDR_CTRL, 8'h01);
    settle(6);
    chk("gate_on", 8'(drive_q.gate_enable), 8'h01);
    chk("pin_gate_on", 8'(pin_drive.gate_enable), 8'h01);
  endtask
  task automatic t_drv_off();
    @(posedge sys_clk) driver_disable_pin <= 1'b1;
    settle(6);
    chk("pulldown", {6'h00, drive_q.gate_enable, drive_q.pulldown_on}, 8'h01);
    @(posedge sys_clk) driver_disable_pin <= 1'b0;
    settle(6);
    chk("gate_back", 8'(drive_q.gate_enable), 8'h01);
  endtask
  task automatic t_glitch();
    @(posedge sys_clk) power_supply_low <= 1'b1;
    settle(4);
    @(posedge sys_clk) power_supply_low <= 1'b0;
    settle(20);
    chk("no_glitch", 8'(fault_line), 8'h01);
  endtask
  task automatic t_uv(input logic m);
    wr(GDFEC_ADDR_IRQ_MASK, 8'h00);
    wr(GDFEC_ADDR_CTRL, {5'h00, m, 2'b01});
    @(posedge sys_clk) power_supply_low <= 1'b1;
    settle(16);
    chk("uv_line", 8'(fault_line), 8'h00);
    chk("uv_drive", {4'h0, drive_q}, 8'h05);
    chk("pin_uv_line", 8'(pin_oe_n), 8'h00);
    rd(GDFEC_ADDR_STATUS);
    chk("uv_status", rv & 8'h03, 8'h03);
    chk("irq_masked", 8'(irq_q), 8'h00);
    wr(GDFEC_ADDR_IRQ_MASK, 8'h07);
    settle(2);
    chk("irq_on", 8'(irq_q), 8'h01);
    rd(GDFEC_ADDR_IRQ_STAT);
    settle(2);
    chk("irq_off", 8'(irq_q), 8'h00);
    @(posedge sys_clk) power_supply_low <= 1'b0;
    settle(20);
    chk("line_after", 8'(fault_line), {7'h00, m});
    chk("cp_after", 8'(drive_q.charge_pump_on), {7'h00, m});
    chk("pin_line_after", 8'(pin_oe_n), 8'h01);
    chk("pin_cp_after", 8'(pin_drive.charge_pump_on), 8'h01);
    rd(GDFEC_ADDR_STATUS);
    chk("uv_kept", 8'(rv[GDFEC_ST_UV_POS]), 8'h01);
    chk("pin_status", pv & 8'h03, 8'h00);
    t_clear(m);
    settle(8);
    chk("line_clr", 8'(fault_line), 8'h01);
    chk("gate_clr", 8'(drive_q.gate_enable), 8'h01);
  endtask
  task automatic t_inactive(input logic by_sleep);
    @(posedge sys_clk);
    sleep_n_pin <= !by_sleep;
    logic_supply_low <= !by_sleep;
    settle(20);
    chk("off_drive", {4'h0, drive_q}, 8'h04);
    @(posedge sys_clk);
    sleep_n_pin <= 1'b1;
    logic_supply_low <= 1'b0;
    settle(10);
    chk("wake_drive", {4'h0, drive_q}, 8'h0b);
    chk("pin_wake_drive", {4'h0, pin_drive}, 8'h0b);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_power_up();
    t_clear(1'b0);
    t_drv_off();
    t_glitch();
    t_uv(1'b0);
    t_uv(1'b1);
    t_inactive(1'b1);
    t_inactive(1'b0);
    rd(GDFEC_ADDR_STATUS);
    chk("por_again", 8'(rv[GDFEC_ST_POR_POS]), 8'h01);
    stop_test();
  end
endmodule // gdfec_top_tb
